/* File: design/dbg_ctl_pkg.sv */
// package for the debugger control and status block
// assumes one system clock domain and a plain register port
package dbg_ctl_pkg;
  localparam logic [0:0] ADDR_CONTROL = 1'h0;
  localparam logic [0:0] ADDR_STATUS = 1'h1;
  localparam int BIT_MODE = 7;
  localparam int BIT_BRK_ENABLE = 5;
  localparam int BIT_SPIN = 4;
  localparam int BIT_CHIP_RESET = 0;
  localparam int BIT_IDLE = 7;
  localparam int BIT_HALT = 6;
  localparam int BIT_RDPROT = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hF1;
  localparam int RESET_SEQ_CYCLES = 16;
  typedef struct packed {
    logic [0:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

/* File: design/dbg_sync3.sv */
// three-stage synchroniser with agreement of stages two and three
// assumes one clock; the first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module dbg_sync3 (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // data
  input wire logic i_d,
  output logic o_q
);
  logic s1_ff, s2_ff, s3_ff, q_ff;
  logic nxt_q;
  always_comb begin
    nxt_q = q_ff;
    if (s2_ff == s3_ff) begin
      nxt_q = s3_ff;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff <= 1'b0;
    end else if (i_ce) begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end
  assign o_q = q_ff;
endmodule
`default_nettype wire

/* File: design/dbg_ctl.sv */
// debugger control and status registers with breakpoint handling
// assumes cpu strobes on this clock; halt and read-protect pins are async
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - break with spin clear sets debugger mode
// - break with spin set makes cpu repeat
// - chip reset request resets all but debugger
// - chip reset request self clears when done
// - idle bit shows mode or break since write
// - halt bit shows low power halt state
// - protect bit is inverse of option bit
module dbg_ctl
  import dbg_ctl_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_SEQ_CYCLES
) (
  // clock, reset, enable
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  // register port
  input wire logic [0:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // cpu side
  input wire logic I_BRK_DECODE,
  input wire logic I_HALT_STATE,
  input wire logic I_RDPROT_OPTION,
  output logic O_DEBUG_MODE,
  output logic O_CPU_REPEAT,
  output logic O_CHIP_RESET
);
  typedef enum logic [0:0] {
    RS_IDLE = 1'b0,
    RS_BUSY = 1'b1
  } rst_e;
  localparam int CW = $clog2(RESET_CYCLES + 1);
  initial begin
    if (RESET_CYCLES < 1) begin
      $error("RESET_CYCLES must be at least one");
    end
  end
  reg_req_s req;
  logic [7:0] ctl_ff, nxt_ctl;
  logic brk_seen_ff, nxt_brk_seen;
  logic [7:0] rdata_ff, nxt_rdata;
  rst_e rst_ff, nxt_rst;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic halt_s, optn_s;
  logic brk_en, spin;
  logic [7:0] status;
  function automatic logic hit(input reg_req_s r, input logic [0:0] a);
    hit = (r.addr == a);
  endfunction
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  dbg_sync3 u_sync_halt (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_ce(I_CE),
    .i_d(I_HALT_STATE),
    .o_q(halt_s)
  );
  dbg_sync3 u_sync_optn (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_ce(I_CE),
    .i_d(I_RDPROT_OPTION),
    .o_q(optn_s)
  );
  assign brk_en = ctl_ff[BIT_BRK_ENABLE];
  assign spin = ctl_ff[BIT_SPIN];
  always_comb begin
    status = 8'h00;
    status[BIT_IDLE] = ctl_ff[BIT_MODE] | brk_seen_ff;
    status[BIT_HALT] = halt_s;
    status[BIT_RDPROT] = ~optn_s;
  end
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_brk_seen = brk_seen_ff;
    nxt_rdata = rdata_ff;
    nxt_rst = rst_ff;
    nxt_cnt = cnt_ff;
    if (req.wr && hit(req, ADDR_CONTROL)) begin
      // reserved bits 3:1 are dropped so they always read zero; reserved bit 6 is stored
      nxt_ctl = req.wdata & CONTROL_WMASK;
      nxt_ctl[BIT_CHIP_RESET] = ctl_ff[BIT_CHIP_RESET] |
        req.wdata[BIT_CHIP_RESET];
      nxt_brk_seen = 1'b0;
    end
    // a break in the same cycle as a write still counts
    if (I_BRK_DECODE && brk_en) begin
      nxt_brk_seen = 1'b1;
      if (!spin) begin
        nxt_ctl[BIT_MODE] = 1'b1;
      end
    end
    case (rst_ff)
      RS_IDLE: begin
        if (ctl_ff[BIT_CHIP_RESET]) begin
          nxt_rst = RS_BUSY;
          nxt_cnt = CW'(RESET_CYCLES - 1);
        end
      end
      RS_BUSY: begin
        if (cnt_ff == '0) begin
          nxt_rst = RS_IDLE;
          // a fresh request landing on the last cycle wins over the clear
          nxt_ctl[BIT_CHIP_RESET] = req.wr && hit(req, ADDR_CONTROL) &&
            req.wdata[BIT_CHIP_RESET];
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_rst = RS_IDLE;
      end
    endcase
    // status writes fall through with no effect
    nxt_rdata = 8'h00;
    if (req.rd) begin
      nxt_rdata = hit(req, ADDR_STATUS) ? status : ctl_ff;
    end
  end
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctl_ff <= CONTROL_RESET;
      brk_seen_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rst_ff <= RS_IDLE;
      cnt_ff <= '0;
    end else if (I_CE) begin
      ctl_ff <= nxt_ctl;
      brk_seen_ff <= nxt_brk_seen;
      rdata_ff <= nxt_rdata;
      rst_ff <= nxt_rst;
      cnt_ff <= nxt_cnt;
    end
  end
  assign O_RDATA = rdata_ff;
  assign O_DEBUG_MODE = ctl_ff[BIT_MODE];
  // cpu keeps re-executing the break while spin is selected
  assign O_CPU_REPEAT = brk_seen_ff & brk_en & spin;
  assign O_CHIP_RESET = (rst_ff == RS_BUSY);
endmodule
`default_nettype wire

/* File: tb/dbg_ctl_properties.sv */
// checker for the debugger control block
// sees top ports only; bench sets RESET_CYCLES to 2
`timescale 1ns/1ns
`default_nettype none
module dbg_ctl_properties #(parameter int RESET_CYCLES = 2) (
  input wire logic I_MCLK, I_RESET, I_CE, I_WR, I_RD,
  input wire logic [0:0] I_ADDR,
  input wire logic [7:0] I_WDATA, O_RDATA,
  input wire logic I_BRK_DECODE, I_HALT_STATE, I_RDPROT_OPTION,
  input wire logic O_DEBUG_MODE, O_CPU_REPEAT, O_CHIP_RESET
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  sequence wc; I_CE && I_WR && !I_ADDR; endsequence
  sequence rs; I_CE && I_RD && I_ADDR; endsequence
  sequence bk; I_CE && I_BRK_DECODE && !I_WR; endsequence
  a_brk_mode: assert property (wc ##0 I_WDATA[7:4] == 4'h2 ##1 bk
    |=> O_DEBUG_MODE) else $error("no mode");
  a_brk_spin: assert property (wc ##0 I_WDATA[7:4] == 4'h3 ##1 bk
    |=> O_CPU_REPEAT && !O_DEBUG_MODE) else $error("no spin");
  a_rst_start: assert property (wc ##0 I_WDATA[0]
    |-> ##2 O_CHIP_RESET) else $error("no chip reset");
  // two high cycles only holds for the shortened sequence
  a_rst_clear: assert property ($rose(O_CHIP_RESET)
    |-> O_CHIP_RESET[*2] ##1 !O_CHIP_RESET) else $error("reset length");
  a_idle_bit: assert property (rs ##0 O_DEBUG_MODE
    |=> O_RDATA[7]) else $error("idle bit");
  // eight steady cycles cover the synchroniser latency
  a_halt_bit: assert property ($stable(I_HALT_STATE)[*8] ##0 rs
    |=> O_RDATA[6] == $past(I_HALT_STATE)) else $error("halt bit");
  a_prot_bit: assert property ($stable(I_RDPROT_OPTION)[*8] ##0 rs
    |=> O_RDATA[5] == !$past(I_RDPROT_OPTION)) else $error("protect bit");
  a_resv_zero: assert property (rs
    |=> O_RDATA[4:0] == 5'h00) else $error("reserved bits");
endmodule
bind dbg_ctl dbg_ctl_properties #(.RESET_CYCLES(RESET_CYCLES)) props_i (.*);
`default_nettype wire

/* File: tb/cpu_model.sv */
// cpu side model: decodes breaks and repeats them while looping
// assumes the bench commands single break instructions
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input wire logic i_clk, i_rst, i_exec, i_repeat, i_debug,
  output logic o_brk
);
  // a cpu stopped in debug mode decodes nothing
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      o_brk <= 1'b0;
    else
      o_brk <= !i_debug && (i_exec || i_repeat);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// bench for the debugger control block with a cpu model
// assumes clock enable held high throughout
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ex = 0, pend = 0;
  logic halt = 0, rpo = 1, breakpoint_instruction, mode, rep, crst;
  logic [7:0] rst_len = 8'h00;
  logic [0:0] adr = 1'h0;
  logic [7:0] wd = 8'h00, rdat, q[$];
  int fails = 0, tests_run = 0;
  int unsigned seed = 78;
  always #5 clk = ~clk;
  dbg_ctl #(.RESET_CYCLES(2)) dbg_ctl_i (.I_MCLK(clk), .I_RESET(rst),
    .I_CE(1'b1), .I_ADDR(adr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdat), .I_BRK_DECODE(breakpoint_instruction), .I_HALT_STATE(halt),
    .I_RDPROT_OPTION(rpo), .O_DEBUG_MODE(mode), .O_CPU_REPEAT(rep),
    .O_CHIP_RESET(crst));
  cpu_model cpu_model_i (.i_clk(clk), .i_rst(rst), .i_exec(ex),
    .i_repeat(rep), .i_debug(mode), .o_brk(breakpoint_instruction));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr_t(input logic a, input logic [7:0] d, input logic b);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1;
    ex <= b;
    @(posedge clk);
    wr <= 0;
    ex <= 0;
  endtask
  task automatic rd_t(input logic a, input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1;
    q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rst(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t reset cycles %0d want %0d", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) pend <= rd;
  always @(posedge clk) if (crst === 1'b1) rst_len <= rst_len + 8'h01;
  always @(negedge clk) if (pend) chk(rdat, q.pop_front());
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (8) @(posedge clk);
    rd_t(1, 8'h00);
    wr_t(0, 8'h20, 1);
    repeat (2) @(posedge clk);
    rd_t(0, 8'hA0);
    rd_t(1, 8'h80);
    wr_t(0, 8'h00, 0);
    wr_t(0, 8'h30, 1);
    repeat (2) @(posedge clk);
    rd_t(0, 8'h30);
    rd_t(1, 8'h80);
    // a looping break may land on the first write, so write twice
    wr_t(0, 8'h00, 0);
    repeat (3) @(posedge clk);
    wr_t(0, 8'h00, 0);
    rd_t(1, 8'h00);
    halt <= 1;
    rpo <= 0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      wr_t(1, rnd() & 8'hE0, 0);
      rd_t(1, 8'h60);
    end
    wr_t(0, 8'h01, 0);
    repeat (6) @(posedge clk);
    rd_t(0, 8'h00);
    chk_rst(rst_len, 8'h02);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
